// File: hdl/ldc_pkg.sv
// Purpose: Shared constants and types for the LED sink configuration bank
// Assumes: 32-bit register port, byte offsets as printed
// Notes: Range code 3 is reserved and never stored
package ldc_pkg;
    // Register byte offsets
    localparam logic [7:0] LDC_OFS_CFG = 8'h00;
    localparam logic [7:0] LDC_OFS_CURR = 8'h04;
    localparam logic [7:0] LDC_OFS_MAN = 8'h20;
    // Output config field positions
    localparam int LDC_POS_REF_EN = 18;
    localparam int LDC_POS_SINK_ON = 8;
    localparam int LDC_POS_RANGE = 0;
    // Manual sequence field positions
    localparam int LDC_POS_MAN_MODE = 26;
    localparam int LDC_POS_ITG_RUN = 23;
    localparam int LDC_POS_SW = 19;
    // Reset values
    localparam logic [1:0] LDC_RANGE_RST = 2'h1;
    localparam logic [7:0] LDC_CODE_RST = 8'h00;
    // Full-scale range codes, in mA
    localparam logic [1:0] LDC_RANGE_25 = 2'h0;
    localparam logic [1:0] LDC_RANGE_50 = 2'h1;
    localparam logic [1:0] LDC_RANGE_100 = 2'h2;
    localparam int LDC_FS_25_MA = 25;
    localparam int LDC_FS_50_MA = 50;
    localparam int LDC_FS_100_MA = 100;
    localparam int LDC_CODE_STEPS = 256;

    // Settings for one sink, index 0 is sink one
    typedef struct packed {
        logic on;
        logic [1:0] range_sel;
        logic [7:0] level_code;
        logic direct_switch;
    } ldc_sink_t;

    // Analog-side controls for all four sinks
    typedef struct packed {
        logic ref_en;
        logic manual_mode;
        logic direct_integrator_run;
        ldc_sink_t [3:0] sink;
    } ldc_ctrl_t;
endpackage : ldc_pkg

// File: hdl/ldc_regs.sv
// Purpose: Register bank steering the four LED current sinks and manual switches
// Assumes: One 100 MHz clock, synchronous active-high reset, no wait states
// Notes: Sink current is analog; the micro-amp estimate is a status output, not readable through the read mux
`timescale 1ns/1ps

module ldc_regs (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // Analog controls
    output ldc_pkg::ldc_ctrl_t ctrl_out,
    // Effective drive per sink: enabled and, in manual mode, switched in
    output logic [3:0] sink_drive_out,
    output logic integrator_reset_out,
    // Target current of each sink in microamps
    output logic [3:0][16:0] sink_ua_out
);

    // Full-scale current in microamps for a range code
    function automatic logic [16:0] fs_ua(input logic [1:0] r);
        case (r)
            ldc_pkg::LDC_RANGE_25: fs_ua = 17'(ldc_pkg::LDC_FS_25_MA * 1000);
            ldc_pkg::LDC_RANGE_50: fs_ua = 17'(ldc_pkg::LDC_FS_50_MA * 1000);
            ldc_pkg::LDC_RANGE_100: fs_ua = 17'(ldc_pkg::LDC_FS_100_MA * 1000);
            default: fs_ua = 17'(ldc_pkg::LDC_FS_50_MA * 1000);
        endcase
    endfunction : fs_ua

    // Sink current estimate; code zero yields nothing
    function automatic logic [16:0] sink_ua(input logic [7:0] c, input logic [1:0] r);
        logic [25:0] prod;
        prod = 26'({1'b0, c} + 9'h001) * 26'(fs_ua(r));
        if (c == 8'h00)
            sink_ua = 17'h00000;
        else
            sink_ua = 17'(prod / 26'(ldc_pkg::LDC_CODE_STEPS));
    endfunction : sink_ua

    ldc_pkg::ldc_ctrl_t ctrl_reg, ctrl_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [3:0] drive_reg, drive_next;
    logic itg_rst_reg, itg_rst_next;
    logic [3:0][16:0] ua_reg, ua_next;

    // Register writes; reserved range code 3 keeps the old value
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (wr_in && addr_in == ldc_pkg::LDC_OFS_CFG)
        begin
            ctrl_next.ref_en = wdata_in[ldc_pkg::LDC_POS_REF_EN];
            for (int i = 0; i < 4; i++)
            begin
                ctrl_next.sink[i].on = wdata_in[ldc_pkg::LDC_POS_SINK_ON + i];
                if (wdata_in[ldc_pkg::LDC_POS_RANGE + 2*i +: 2] != 2'h3)
                    ctrl_next.sink[i].range_sel = wdata_in[ldc_pkg::LDC_POS_RANGE + 2*i +: 2];
            end
        end
        if (wr_in && addr_in == ldc_pkg::LDC_OFS_CURR)
        begin
            for (int i = 0; i < 4; i++)
                ctrl_next.sink[i].level_code = wdata_in[8*i +: 8];
        end
        if (wr_in && addr_in == ldc_pkg::LDC_OFS_MAN)
        begin
            ctrl_next.manual_mode = wdata_in[ldc_pkg::LDC_POS_MAN_MODE];
            ctrl_next.direct_integrator_run = wdata_in[ldc_pkg::LDC_POS_ITG_RUN];
            for (int i = 0; i < 4; i++)
                ctrl_next.sink[i].direct_switch = wdata_in[ldc_pkg::LDC_POS_SW + i];
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rdata_next = 32'h00000000;
        if (rd_in)
        begin
            case (addr_in)
                ldc_pkg::LDC_OFS_CFG:
                begin
                    rdata_next[ldc_pkg::LDC_POS_REF_EN] = ctrl_reg.ref_en;
                    for (int i = 0; i < 4; i++)
                    begin
                        rdata_next[ldc_pkg::LDC_POS_SINK_ON + i] = ctrl_reg.sink[i].on;
                        rdata_next[ldc_pkg::LDC_POS_RANGE + 2*i +: 2] = ctrl_reg.sink[i].range_sel;
                    end
                end
                ldc_pkg::LDC_OFS_CURR:
                begin
                    for (int i = 0; i < 4; i++)
                        rdata_next[8*i +: 8] = ctrl_reg.sink[i].level_code;
                end
                ldc_pkg::LDC_OFS_MAN:
                begin
                    rdata_next[ldc_pkg::LDC_POS_MAN_MODE] = ctrl_reg.manual_mode;
                    rdata_next[ldc_pkg::LDC_POS_ITG_RUN] = ctrl_reg.direct_integrator_run;
                    for (int i = 0; i < 4; i++)
                        rdata_next[ldc_pkg::LDC_POS_SW + i] = ctrl_reg.sink[i].direct_switch;
                end
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    // Derived drive: switches matter only in manual mode, else sequencer owns them
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            drive_next[i] = ctrl_next.sink[i].on &
                (~ctrl_next.manual_mode | ctrl_next.sink[i].direct_switch);
            ua_next[i] = sink_ua(ctrl_next.sink[i].level_code, ctrl_next.sink[i].range_sel);
        end
        itg_rst_next = ctrl_next.manual_mode & ~ctrl_next.direct_integrator_run;
    end

    // State registers
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_reg.ref_en <= 1'b0;
            ctrl_reg.manual_mode <= 1'b0;
            ctrl_reg.direct_integrator_run <= 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                ctrl_reg.sink[i].on <= 1'b0;
                ctrl_reg.sink[i].range_sel <= ldc_pkg::LDC_RANGE_RST;
                ctrl_reg.sink[i].level_code <= ldc_pkg::LDC_CODE_RST;
                ctrl_reg.sink[i].direct_switch <= 1'b0;
            end
            rdata_reg <= 32'h00000000;
            drive_reg <= 4'h0;
            itg_rst_reg <= 1'b0;
            ua_reg <= '0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
            drive_reg <= drive_next;
            itg_rst_reg <= itg_rst_next;
            ua_reg <= ua_next;
        end
    end

    assign rdata_out = rdata_reg;
    assign ctrl_out = ctrl_reg;
    assign sink_drive_out = drive_reg;
    assign integrator_reset_out = itg_rst_reg;
    assign sink_ua_out = ua_reg;

    // Checks
    a_ref_en_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_in && addr_in == ldc_pkg::LDC_OFS_CFG |=>
        ctrl_out.ref_en == $past(wdata_in[ldc_pkg::LDC_POS_REF_EN]))
        else $error("reference enable not written");
    a_sink_on_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_in && addr_in == ldc_pkg::LDC_OFS_CFG |=>
        ctrl_out.sink[3].on == $past(wdata_in[ldc_pkg::LDC_POS_SINK_ON + 3]))
        else $error("sink four enable not written");
    a_range_legal: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ctrl_out.sink[3].range_sel != 2'h3 && ctrl_out.sink[0].range_sel != 2'h3)
        else $error("reserved range code stored");
    // Legal range code lands; the reserved code leaves the field alone
    a_range_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_in && addr_in == ldc_pkg::LDC_OFS_CFG && wdata_in[7:6] != 2'h3 |=>
        ctrl_out.sink[3].range_sel == $past(wdata_in[7:6]))
        else $error("sink four range not written");
    a_range_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_in && addr_in == ldc_pkg::LDC_OFS_CFG && wdata_in[7:6] == 2'h3 |=>
        $stable(ctrl_out.sink[3].range_sel))
        else $error("reserved range code changed sink four");
    // Watched at the first edge after release, so no history before reset counts
    a_range_reset: assert property (@(posedge clk_in)
        $past(sys_rst_in) && !sys_rst_in |->
        ctrl_out.sink[0].range_sel == ldc_pkg::LDC_RANGE_RST &&
        ctrl_out.sink[1].range_sel == ldc_pkg::LDC_RANGE_RST &&
        ctrl_out.sink[2].range_sel == ldc_pkg::LDC_RANGE_RST)
        else $error("range reset value wrong");
    a_code_reset: assert property (@(posedge clk_in)
        $past(sys_rst_in) && !sys_rst_in |->
        ctrl_out.sink[0].level_code == ldc_pkg::LDC_CODE_RST &&
        ctrl_out.sink[3].level_code == ldc_pkg::LDC_CODE_RST)
        else $error("current code reset value wrong");
    a_code_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_in && addr_in == ldc_pkg::LDC_OFS_CURR |=>
        ctrl_out.sink[0].level_code == $past(wdata_in[7:0]))
        else $error("sink one current code not written");
    a_code_readback: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_in && addr_in == ldc_pkg::LDC_OFS_CURR ##1
        rd_in && addr_in == ldc_pkg::LDC_OFS_CURR |=>
        rdata_out == $past(wdata_in, 2))
        else $error("current codes readback mismatch");
    // Estimate is registered beside the codes, so it must match in the same cycle
    a_current_calc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ctrl_out.sink[2].level_code == 8'hff &&
        ctrl_out.sink[2].range_sel == ldc_pkg::LDC_RANGE_100 |->
        sink_ua_out[2] == 17'(ldc_pkg::LDC_FS_100_MA * 1000))
        else $error("full code not full scale");
    a_integrator_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        integrator_reset_out |-> ctrl_out.manual_mode && !ctrl_out.direct_integrator_run)
        else $error("integrator reset outside manual hold");
    a_manual_switch: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ctrl_out.manual_mode && !ctrl_out.sink[3].direct_switch |-> !sink_drive_out[3])
        else $error("sink four driven while switched out");
    a_switch_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_in && addr_in == ldc_pkg::LDC_OFS_MAN |=>
        ctrl_out.sink[3].direct_switch == $past(wdata_in[ldc_pkg::LDC_POS_SW + 3]))
        else $error("sink four switch not written");
    a_sink_one_switch: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ctrl_out.manual_mode && !ctrl_out.sink[0].direct_switch |-> !sink_drive_out[0])
        else $error("sink one driven while switched out");
    a_manual_drive: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ctrl_out.manual_mode |->
        sink_drive_out[1] == (ctrl_out.sink[1].on && ctrl_out.sink[1].direct_switch))
        else $error("sink two drive wrong in manual mode");
    a_manual_mode_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_in && addr_in == ldc_pkg::LDC_OFS_MAN |=>
        ctrl_out.manual_mode == $past(wdata_in[ldc_pkg::LDC_POS_MAN_MODE]))
        else $error("manual mode not written");
    a_auto_ignores: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !ctrl_out.manual_mode |-> sink_drive_out == {ctrl_out.sink[3].on, ctrl_out.sink[2].on,
        ctrl_out.sink[1].on, ctrl_out.sink[0].on})
        else $error("manual switch acted outside manual mode");

endmodule : ldc_regs

// File: tb/tb.sv
// Purpose: Self-checking bench for the LED sink configuration bank
// Assumes: Register port without wait states, read data one cycle after strobe
// Notes: Random traffic from a fixed seed, with hand-picked corner writes
`timescale 1ns/1ps
module tb;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic [31:0] rdata_out;
    ldc_pkg::ldc_ctrl_t ctrl_out;
    logic [3:0] sink_drive_out;
    logic integrator_reset_out;
    logic [3:0][16:0] sink_ua_out;
    int fails = 0;
    int comparisons = 0;
    logic [31:0] cfg_m, cur_m, man_m;
    logic [7:0] a;

    ldc_regs DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .ctrl_out(ctrl_out), .sink_drive_out(sink_drive_out),
        .integrator_reset_out(integrator_reset_out), .sink_ua_out(sink_ua_out));

    // Free-running 100 MHz clock
    initial
    begin
        forever #5 clk_in = ~clk_in;
    end

    task automatic end_sim;
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Truncated micro-amp target; code zero yields nothing
    function automatic logic [16:0] exp_ua(input logic [7:0] c, input logic [1:0] r);
        int fs;
        fs = (r == ldc_pkg::LDC_RANGE_25) ? ldc_pkg::LDC_FS_25_MA * 1000 :
             (r == ldc_pkg::LDC_RANGE_50) ? ldc_pkg::LDC_FS_50_MA * 1000 :
             ldc_pkg::LDC_FS_100_MA * 1000;
        if (c == 8'h00) return 17'h0;
        return 17'((int'(c) + 1) * fs / ldc_pkg::LDC_CODE_STEPS);
    endfunction : exp_ua

    // Compare every output except rdata_out against the shadow registers
    task automatic chk_out;
        ldc_pkg::ldc_ctrl_t e;
        logic [3:0] d;
        logic [3:0][16:0] u;
        e.ref_en = cfg_m[18];
        e.manual_mode = man_m[26];
        e.direct_integrator_run = man_m[23];
        for (int i = 0; i < 4; i++)
        begin
            e.sink[i].on = cfg_m[8 + i];
            e.sink[i].range_sel = cfg_m[2 * i +: 2];
            e.sink[i].level_code = cur_m[8 * i +: 8];
            e.sink[i].direct_switch = man_m[19 + i];
            d[i] = e.sink[i].on & (!e.manual_mode | e.sink[i].direct_switch);
            u[i] = exp_ua(e.sink[i].level_code, e.sink[i].range_sel);
        end
        chk(128'(ctrl_out), 128'(e));
        chk(128'(sink_drive_out), 128'(d));
        chk(128'(integrator_reset_out), 128'(e.manual_mode & !e.direct_integrator_run));
        chk(128'(sink_ua_out), 128'(u));
    endtask : chk_out

    // Shadow registers take a write as the bank should store it
    task automatic upd_shadow(input logic [7:0] ad, input logic [31:0] d);
        if (ad == ldc_pkg::LDC_OFS_CFG)
        begin
            cfg_m[18] = d[18];
            cfg_m[11:8] = d[11:8];
            for (int i = 0; i < 4; i++)
                if (d[2 * i +: 2] != 2'h3) cfg_m[2 * i +: 2] = d[2 * i +: 2];
        end
        else if (ad == ldc_pkg::LDC_OFS_CURR) cur_m = d;
        else if (ad == ldc_pkg::LDC_OFS_MAN) man_m = d & 32'h04f8_0000;
    endtask : upd_shadow

    // Expected read data; unmapped offsets read zero
    function automatic logic [31:0] exp_rd(input logic [7:0] ad);
        return (ad == ldc_pkg::LDC_OFS_CFG) ? cfg_m : (ad == ldc_pkg::LDC_OFS_CURR) ? cur_m :
            (ad == ldc_pkg::LDC_OFS_MAN) ? man_m : 32'h0;
    endfunction : exp_rd

    // One-cycle write, shadow updated as the bank should
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= ad;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        upd_shadow(ad, d);
        #1 chk_out();
    endtask : wr

    // Write then read of one offset, strobes back to back
    task automatic wr_rd(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= ad;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        upd_shadow(ad, d);
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(128'(rdata_out), 128'(exp_rd(ad)));
        chk_out();
    endtask : wr_rd

    // Read data stands one cycle only, then returns to zero
    task automatic rd(input logic [7:0] ad);
        logic [31:0] e;
        e = exp_rd(ad);
        @(posedge clk_in);
        addr_in <= ad;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(128'(rdata_out), 128'(e));
        @(posedge clk_in);
        #1 chk(128'(rdata_out), 128'h0);
    endtask : rd

    // Reset held eight cycles; shadow back to documented defaults
    task automatic rst_seq;
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        cfg_m = 32'h0000_0055;
        cur_m = 32'h0;
        man_m = 32'h0;
        #1 chk_out();
    endtask : rst_seq

    // Guard against a hung sequence
    initial
    begin
        repeat (5000) @(posedge clk_in);
        fails++;
        end_sim();
    end

    initial
    begin
        void'($urandom(35));
        rst_seq();
        rd(ldc_pkg::LDC_OFS_CFG);
        rd(ldc_pkg::LDC_OFS_CURR);
        rd(ldc_pkg::LDC_OFS_MAN);
        // Code 3 everywhere must leave ranges alone
        wr(ldc_pkg::LDC_OFS_CFG, 32'hffff_ffff);
        wr(ldc_pkg::LDC_OFS_CFG, 32'h0004_0fe4);
        wr(ldc_pkg::LDC_OFS_CURR, 32'h80ff_0100);
        wr_rd(ldc_pkg::LDC_OFS_CURR, 32'h0102_fe7f);
        wr(ldc_pkg::LDC_OFS_MAN, 32'h0400_0000);
        wr(ldc_pkg::LDC_OFS_MAN, 32'h04a8_0000);
        wr(ldc_pkg::LDC_OFS_MAN, 32'h00f8_0000);
        wr(8'h24, 32'hffff_ffff);
        rd(8'h24);
        repeat (60)
        begin
            case ($urandom % 4)
                0: a = ldc_pkg::LDC_OFS_CFG;
                1: a = ldc_pkg::LDC_OFS_CURR;
                2: a = ldc_pkg::LDC_OFS_MAN;
                default: a = 8'($urandom);
            endcase
            wr(a, $urandom);
            rd(a);
            wr_rd(a, $urandom);
        end
        rst_seq();
        rd(ldc_pkg::LDC_OFS_CFG);
        end_sim();
    end
endmodule : tb
